/* fuse_parameter_readout.sv */
// Fuse parameter readout: load sequencer, decoder, APB registers, events
//
// Design decisions made here: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "fuse_parameter_readout_map.svh"

module fuse_parameter_readout #(
   parameter int FUSE_ADDR_W = 5                // Fuse word address width
)(
   input  wire  logic                    pclk,          // Bus clock, 25 MHz
   input  wire  logic                    presetn,       // Async reset, low
   input  wire  logic [11:0]             paddr,         // APB byte address
   input  wire  logic                    psel,          // APB select
   input  wire  logic                    penable,       // APB access phase
   input  wire  logic                    pwrite,        // APB write
   input  wire  logic [31:0]             pwdata,        // APB write data
   output logic       [31:0]             prdata,        // APB read data
   output logic                          pready,        // APB ready
   output logic                          pslverr,       // APB error
   output logic                          fuse_rd_en,    // Fuse word read strobe
   output logic       [FUSE_ADDR_W-1:0]  fuse_addr,     // Fuse word index
   input  wire  logic [31:0]             fuse_rd_data,  // Fuse word, while strobe stands
   output logic                          burn_start,    // Burn request pulse
   input  wire  logic                    burn_done,     // Burn finished pulse
   output logic                          irq,           // Level interrupt
   output logic       [6:0][31:0]        hw_sysparam,   // Fixed parameter words
   output logic       [255:0]            hw_key_one,    // Decoded key block one
   output logic       [255:0]            hw_key_two,    // Decoded key block two
   output logic       [255:0]            hw_key_three   // Decoded key block three
);

   // ----------------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------------
   // Thirty-one fuse words must be addressable
   if (FUSE_ADDR_W < 5)
   begin : g_addr_check
      $error("FUSE_ADDR_W must be at least 5");
   end

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      fuse_parameter_readout_pkg::seq_t seq;     // Sequencer state
      logic [4:0]                       idx;     // Fuse word being read
      logic [6:0][31:0]                 sys;     // Fixed parameter words
      logic [23:0][31:0]                raw;     // Encoded key words
      logic [2:0][255:0]                key;     // Decoded key blocks
      logic [1:0]                       cmd;     // Command register
      logic [1:0]                       ev;      // Sticky event bits
      logic [1:0]                       ena;     // Event mask
      logic                             irq;     // Interrupt level
      logic [31:0]                      rdata;   // Read data
      logic                             ready;   // Access phase answer
      logic                             err;     // Unmapped access
      logic                             rd_en;   // Fuse read strobe
      logic                             burn;    // Burn request pulse
   } state_t;

   state_t s_q;                                  // Registered state
   state_t s_d;                                  // Next state

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Field mask of a fixed parameter word; reserved bits read zero
   function automatic logic [31:0] sys_mask(input logic [2:0] w);
      logic [31:0] m;
      m = 32'h0000_0000;
      // Unburnable gaps between fields must never leak to software
      case (w)
         3'h0:    m = `MASK_SYS_WORD0;
         3'h1:    m = `MASK_SYS_WORD1;
         3'h2:    m = `MASK_SYS_WORD2;
         3'h3:    m = `MASK_SYS_WORD3;
         3'h4:    m = `MASK_SYS_WORD4;
         3'h5:    m = `MASK_SYS_WORD5;
         3'h6:    m = `MASK_SYS_WORD6;
         default: m = 32'h0000_0000;
      endcase
      return m;
   endfunction : sys_mask

   // Turn stored fuse contents back into the parameter value
   function automatic logic [255:0] decode_key(input logic [255:0] enc,
                                               input logic [1:0]   scheme);
      logic [255:0] dec;
      dec = '0;
      case (scheme)
         `SCHEME_THREEQ:
         begin
            // Six data bytes per 64-bit group, two check bytes dropped
            for (int g = 0; g < 4; g++)
            begin
               dec[48*g +: 48] = enc[64*g +: 48];
            end
         end
         `SCHEME_REPEAT:
         begin
            // Bit counts as burned when either copy is burned
            dec[127:0] = enc[127:0] | enc[255:128];
         end
         default:
         begin
            dec = enc;
         end
      endcase
      return dec;
   endfunction : decode_key

   // Whether an address names a register of this block
   function automatic logic addr_ok(input logic [11:0] a);
      logic ok;
      ok = 1'b0;
      if (a[1:0] == 2'h0)
      begin
         if (a <= `OFS_SYS_WORD6)
            ok = 1'b1;
         if (a >= `OFS_KEY_ONE && a <= `OFS_KEY_THREE + 12'h01C)
            ok = 1'b1;
         if (a >= `OFS_CMD && a <= `OFS_EV_CLR)
            ok = 1'b1;
      end
      return ok;
   endfunction : addr_ok

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   // One process for bus decode, sequencer and events
   always_comb
   begin
      logic        wr;         // Write takes effect this edge
      logic [1:0]  set;        // Events raised this cycle
      logic [1:0]  clr;        // Events cleared by software
      logic [4:0]  ri;         // Key word index of a fuse word
      logic [255:0] enc;       // Gathered encoded block
      logic [11:0] base;       // Key block base offset
      logic [11:0] koff;       // Offset inside a key block
      s_d   = s_q;
      wr    = psel && penable && pwrite && s_q.ready;
      set   = 2'h0;
      clr   = 2'h0;
      ri    = 5'h00;
      enc   = '0;
      base  = 12'h000;
      koff  = 12'h000;

      // Single-cycle strobes drop by default
      s_d.rd_en = 1'b0;
      s_d.burn  = 1'b0;

      // Bus: read data is prepared in the setup phase, so no wait states
      s_d.ready = psel && !penable;
      s_d.err   = 1'b0;
      if (psel && !penable)
      begin
         s_d.rdata = 32'h0000_0000;
         s_d.err   = !addr_ok(paddr);
         // Refused places answer zero; a misaligned address inside a
         // mapped range must not alias onto the word below it
         if (addr_ok(paddr))
         begin
            if (paddr <= `OFS_SYS_WORD6)
               s_d.rdata = s_q.sys[paddr[4:2]];
            for (int b = 0; b < 3; b++)
            begin
               // Word offset from the full difference: the low address
               // bits alone go negative where a block crosses alignment
               base = `OFS_KEY_ONE + 12'(32 * b);
               koff = paddr - base;
               if (paddr >= base && paddr <= base + 12'h01C)
                  s_d.rdata = s_q.key[b][32*koff[4:2] +: 32];
            end
            case (paddr)
               `OFS_CMD:    s_d.rdata = {30'h0, s_q.cmd};
               `OFS_EV_RAW: s_d.rdata = {30'h0, s_q.ev};
               `OFS_EV_ENA: s_d.rdata = {30'h0, s_q.ena};
               `OFS_EV_ST:  s_d.rdata = {30'h0, s_q.ev & s_q.ena};
               default:     s_d.rdata = s_d.rdata;
            endcase
         end
      end

      // Register writes; parameter words are read-only and ignore writes
      if (wr && paddr == `OFS_EV_ENA)
         s_d.ena = pwdata[1:0];
      if (wr && paddr == `OFS_EV_CLR)
         clr = pwdata[1:0];

      // Sequencer
      case (s_q.seq)
         fuse_parameter_readout_pkg::ST_IDLE:
         begin
            // Commands are only taken while idle; others are dropped
            if (wr && paddr == `OFS_CMD && pwdata == `CMD_LOAD)
            begin
               s_d.cmd = 2'(`CMD_LOAD);
               s_d.idx = 5'h00;
               s_d.seq = fuse_parameter_readout_pkg::ST_RD_ISSUE;
            end
            else if (wr && paddr == `OFS_CMD && pwdata == `CMD_BURN)
            begin
               s_d.cmd  = 2'(`CMD_BURN);
               s_d.burn = 1'b1;
               s_d.seq  = fuse_parameter_readout_pkg::ST_BURN;
            end
         end
         fuse_parameter_readout_pkg::ST_RD_ISSUE:
         begin
            s_d.rd_en = 1'b1;
            s_d.seq   = fuse_parameter_readout_pkg::ST_RD_WAIT;
         end
         fuse_parameter_readout_pkg::ST_RD_WAIT:
         begin
            // Array answers in the cycle the strobe stands
            if (s_q.idx < 5'(`SYS_WORDS))
            begin
               s_d.sys[s_q.idx[2:0]] = fuse_rd_data & sys_mask(s_q.idx[2:0]);
            end
            else
            begin
               ri = s_q.idx - 5'(`SYS_WORDS);
               s_d.raw[ri] = fuse_rd_data;
            end
            if (s_q.idx == `LAST_FUSE_WORD)
               s_d.seq = fuse_parameter_readout_pkg::ST_DECODE;
            else
            begin
               s_d.idx = s_q.idx + 5'h01;
               s_d.seq = fuse_parameter_readout_pkg::ST_RD_ISSUE;
            end
         end
         fuse_parameter_readout_pkg::ST_DECODE:
         begin
            // Scheme comes from the freshly loaded word 6
            for (int b = 0; b < 3; b++)
            begin
               for (int k = 0; k < `KEY_WORDS; k++)
                  enc[32*k +: 32] = s_q.raw[8*b + k];
               s_d.key[b] = decode_key(enc, s_q.sys[6][1:0]);
            end
            s_d.cmd = `CMD_IDLE;
            set[`EV_LOAD_BIT] = 1'b1;
            s_d.seq = fuse_parameter_readout_pkg::ST_IDLE;
         end
         fuse_parameter_readout_pkg::ST_BURN:
         begin
            if (burn_done)
            begin
               s_d.cmd = `CMD_IDLE;
               set[`EV_BURN_BIT] = 1'b1;
               s_d.seq = fuse_parameter_readout_pkg::ST_IDLE;
            end
         end
         default:
         begin
            s_d.seq = fuse_parameter_readout_pkg::ST_IDLE;
         end
      endcase

      // An event in the clearing cycle survives the clear
      s_d.ev  = (s_q.ev & ~clr) | set;
      s_d.irq = |(s_d.ev & s_d.ena);
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   // Read values stay put between loads; bus reads change nothing here
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q     <= '0;
         s_q.seq <= fuse_parameter_readout_pkg::ST_IDLE;
         s_q.ev  <= `EV_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Hardware consumers see the flops directly, no software path   
   assign prdata       = s_q.rdata;
   assign pready       = s_q.ready;
   assign pslverr      = s_q.err;
   assign fuse_rd_en   = s_q.rd_en;
   assign fuse_addr    = FUSE_ADDR_W'(s_q.idx);
   assign burn_start   = s_q.burn;
   assign irq          = s_q.irq;
   assign hw_sysparam  = s_q.sys;
   assign hw_key_one   = s_q.key[0];
   assign hw_key_two   = s_q.key[1];
   assign hw_key_three = s_q.key[2];

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   // Zero wait states: ready stands only in the access cycle
   AST_READY_AFTER_SETUP: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready && !$past(pready))
      else $error("Ready did not follow setup phase");

   // Refused places answer an error and zero data
   AST_UNMAPPED_ERROR: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable && !addr_ok(paddr) |=> pslverr && prdata == 32'h0000_0000)
      else $error("Unmapped access not flagged");

   AST_LOAD_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.seq == fuse_parameter_readout_pkg::ST_DECODE |=> s_q.ev[0] && s_q.cmd == 2'h0)
      else $error("Load finish did not raise event and clear command");

   AST_BURN_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.seq == fuse_parameter_readout_pkg::ST_BURN && burn_done |=> s_q.ev[1])
      else $error("Burn finish did not raise event");

   // Interrupt line follows the unmasked sticky bits
   AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
      irq == |(s_q.ev & s_q.ena))
      else $error("Interrupt level disagrees with events");

   AST_REPEAT_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.seq == fuse_parameter_readout_pkg::ST_DECODE && s_q.sys[6][1:0] == 2'h2
      |=> hw_key_one[255:128] == '0 && hw_key_three[255:128] == '0)
      else $error("Repeat scheme upper bits not zero");

   AST_THREEQ_WIDTH: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.seq == fuse_parameter_readout_pkg::ST_DECODE && s_q.sys[6][1:0] == 2'h1
      |=> hw_key_two[255:192] == '0 && hw_key_two[47:0] == 48'($past(s_q.raw[9:8])))
      else $error("Three-quarter decode wrong");

   AST_NONE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.seq == fuse_parameter_readout_pkg::ST_DECODE && s_q.sys[6][1:0] == 2'h0
      |=> hw_key_one == $past(s_q.raw[7:0]))
      else $error("None scheme key differs from fuse data");

   // Bus traffic while idle must not disturb loaded values
   AST_KEEP_VALUES: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.seq == fuse_parameter_readout_pkg::ST_IDLE |=> $stable(s_q.key) && $stable(s_q.sys))
      else $error("Read values changed outside a load");

   // An event raised in the clearing cycle is not lost
   AST_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.seq == fuse_parameter_readout_pkg::ST_DECODE && psel && penable && pwrite
      && pready && paddr == `OFS_EV_CLR && pwdata[0] |=> s_q.ev[0])
      else $error("Clear beat a simultaneous event");

   // Unused fuse bits of words 0 and 2 never reach the hardwired words
   AST_WORD0_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
      hw_sysparam[0][31:28] == 4'h0 && hw_sysparam[2][31:24] == 8'h00)
      else $error("Reserved parameter bits not zero");

   // Key block one moves only in the decode cycle, never mid-load
   AST_KEY_ONLY_AT_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.seq != fuse_parameter_readout_pkg::ST_DECODE |=> $stable(hw_key_one))
      else $error("Key block changed outside the decode cycle");

   // A finished burn frees the command register
   AST_BURN_CMD_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
      s_q.seq == fuse_parameter_readout_pkg::ST_BURN && burn_done |=> s_q.cmd == 2'h0)
      else $error("Command not cleared after burn");

   // The array strobe is a single-cycle pulse
   AST_STROBE_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_rd_en |=> !fuse_rd_en)
      else $error("Fuse read strobe longer than one cycle");

endmodule : fuse_parameter_readout
`default_nettype wire

/* fuse_parameter_readout_map.svh */
// Register offsets, field layouts and constants of the fuse parameter readout
//
// Behaviour
// - Every parameter bit reads back through one register bit
// - None scheme: all 256 key bits valid
// - Three-quarter scheme: key bits 191:0 valid
// - Repeat scheme: key bits 127:0 valid
// - Software reads decoded key values, never encoded
// - Hardware gets parameters over fixed, unalterable wires
// - Hardware key outputs carry decoded values
// - Burn completion raises burn finished event
// - Read completion after refresh raises load event
// - Word 0: write lock, read lock, counter
// - Station address split over words 1 and 2
// - Word 3: hold pad setting and revision
// - Word 4: sdio power, voltage, force bits
// - Word 6: scheme select and disable flags
// - Key word k returns block bits 32k+31:32k
// - Command 1 starts load, cleared when done
// - Event bit 1 burn, bit 0 load; write-one clear
`ifndef FUSE_PARAMETER_READOUT_MAP_SVH
`define FUSE_PARAMETER_READOUT_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_SYS_WORD0    12'h000
`define OFS_SYS_WORD6    12'h018
`define OFS_KEY_ONE      12'h038
`define OFS_KEY_TWO      12'h058
`define OFS_KEY_THREE    12'h078
`define OFS_CMD          12'h100
`define OFS_EV_RAW       12'h104
`define OFS_EV_ENA       12'h108
`define OFS_EV_ST        12'h10C
`define OFS_EV_CLR       12'h110

// ----------------------------------------------------------------------
// Field layouts and reset values
// ----------------------------------------------------------------------
`define MASK_SYS_WORD0   32'h0FFF_FFFF
`define MASK_SYS_WORD1   32'hFFFF_FFFF
`define MASK_SYS_WORD2   32'h00FF_FFFF
`define MASK_SYS_WORD3   32'h0000_5FF0
`define MASK_SYS_WORD4   32'h0001_C000
`define MASK_SYS_WORD5   32'hF00F_FFFF
`define MASK_SYS_WORD6   32'h0000_07F7
`define SCHEME_NONE      2'h0
`define SCHEME_THREEQ    2'h1
`define SCHEME_REPEAT    2'h2
`define CMD_LOAD         32'h0000_0001
`define CMD_BURN         32'h0000_0002
`define CMD_IDLE         2'h0
`define EV_LOAD_BIT      0
`define EV_BURN_BIT      1
`define EV_RESET         2'h0
`define SYS_WORDS        7
`define KEY_WORDS        8
`define LAST_FUSE_WORD   5'h1E

`endif

/* fuse_parameter_readout_pkg.sv */
// Types shared by the fuse parameter readout design
`default_nettype none
package fuse_parameter_readout_pkg;

   // ----------------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_RD_ISSUE,
      ST_RD_WAIT,
      ST_DECODE,
      ST_BURN
   } seq_t;

endpackage : fuse_parameter_readout_pkg
`default_nettype wire

/* fuse_array_model.sv */
// Behavioural fuse array that answers the readout block's word reads
`timescale 1ns/100ps
`default_nettype none
module fuse_array_model (
   input  wire logic        pclk,        // Bus clock
   input  wire logic        rd_en,       // Word read strobe
   input  wire logic [4:0]  addr,        // Word index
   output logic      [31:0] rd_data,     // Word data
   input  wire logic        burn_start,  // Burn request pulse
   output logic             burn_done    // Burn finished pulse
);
   logic [31:0] mem [0:30];  // Fuse contents, filled by the bench
   int          burn_wait;   // Burn length, set by the bench
   int          burn_cnt;    // Cycles left of a burn
   logic [31:0] junk;        // Pattern shown outside a strobe

   initial
   begin
      junk      = 32'h5A5A_A5A5;
      burn_done = 1'b0;
      burn_cnt  = 0;
      burn_wait = 3;
   end

   // ------
   // Read port
   // ------
   // Word shows while the strobe stands and is taken at the edge ending it;
   // otherwise a flipping pattern, so a mistimed sample cannot pass by luck
   assign rd_data = rd_en ? mem[addr] : junk;

   always @(posedge pclk)
   begin
      junk <= ~junk;
   end

   // ------
   // Burn timer: prompt or slow as the bench asks
   // ------
   always @(posedge pclk)
   begin
      burn_done <= 1'b0;
      if (burn_start)
         burn_cnt <= burn_wait;
      else if (burn_cnt == 1)
      begin
         burn_done <= 1'b1;
         burn_cnt  <= 0;
      end
      else if (burn_cnt > 1)
         burn_cnt <= burn_cnt - 1;
   end
endmodule : fuse_array_model
`default_nettype wire

/* fuse_parameter_readout_bench.sv */
// Self-checking bench of the fuse parameter readout block
`timescale 1ns/100ps
`default_nettype none
`include "fuse_parameter_readout_map.svh"
module fuse_parameter_readout_bench;
   logic              pclk = 1'b0;  // Bus clock
   logic              presetn;      // Reset, low
   logic [11:0]       paddr;        // APB address
   logic              psel;         // APB select
   logic              penable;      // APB enable
   logic              pwrite;       // APB direction
   logic [31:0]       pwdata;       // APB write data
   logic [31:0]       prdata;       // APB read data
   logic              pready;       // APB ready
   logic              pslverr;      // APB error
   logic              fuse_rd_en;   // Array strobe
   logic [4:0]        fuse_addr;    // Array index
   logic [31:0]       fuse_rd_data; // Array data
   logic              burn_start;   // Burn request
   logic              burn_done;    // Burn finished
   logic              irq;          // Interrupt
   logic [6:0][31:0]  hw_sysparam;  // Hardwired words
   logic [255:0]      hw_key_one;   // Hardwired key one
   logic [255:0]      hw_key_two;   // Hardwired key two
   logic [255:0]      hw_key_three; // Hardwired key three
   int                failures;     // Mismatch count
   int                cmp_count;    // Compare count
   int                seed;         // Random seed
   logic [31:0]       img [0:30];   // Snapshot of last loaded fuses
   logic [31:0]       sys_mask [0:6] = '{`MASK_SYS_WORD0, `MASK_SYS_WORD1,
      `MASK_SYS_WORD2, `MASK_SYS_WORD3, `MASK_SYS_WORD4, `MASK_SYS_WORD5,
      `MASK_SYS_WORD6};

   always #20 pclk = ~pclk;

   fuse_parameter_readout #(.FUSE_ADDR_W(5)) i_dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .fuse_rd_en(fuse_rd_en),
      .fuse_addr(fuse_addr), .fuse_rd_data(fuse_rd_data), .burn_start(burn_start),
      .burn_done(burn_done), .irq(irq), .hw_sysparam(hw_sysparam),
      .hw_key_one(hw_key_one), .hw_key_two(hw_key_two), .hw_key_three(hw_key_three));

   fuse_array_model i_fuse (.pclk(pclk), .rd_en(fuse_rd_en), .addr(fuse_addr),
      .rd_data(fuse_rd_data), .burn_start(burn_start), .burn_done(burn_done));

   // ------
   // Checking and closing
   // ------
   task automatic chk(input string nm, input logic [255:0] seen, input logic [255:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic complete_run;
      $display("Compares %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   // Decoded key block from the snapshot, as the coding scheme defines it
   function automatic logic [255:0] exp_key(input int b, input logic [1:0] s);
      logic [255:0] raw;
      logic [255:0] r;
      r = '0;
      for (int k = 0; k < 8; k++)
         raw[32*k +: 32] = img[7 + 8*b + k];
      if (s == `SCHEME_THREEQ)
         for (int g = 0; g < 4; g++)
            r[48*g +: 48] = raw[64*g +: 48];
      else if (s == `SCHEME_REPEAT)
         r[127:0] = raw[127:0] | raw[255:128];
      else
         r = raw;
      return r;
   endfunction : exp_key

   // ------
   // APB master: one idle edge first so no signal is driven twice at once
   // ------
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (n >= 50)
         failures++;
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Poll the command register until the sequencer goes idle
   task automatic wait_cmd;
      logic [31:0] r;
      logic        e;
      int          n;
      n = 0;
      r = 32'h0000_0001;
      while (r !== 32'h0000_0000 && n < 200)
      begin
         apb(1'b0, `OFS_CMD, '0, r, e);
         n++;
      end
      chk("cmd_idle", r, 32'h0000_0000);
   endtask : wait_cmd

   // ------
   // Load with a given scheme, then check every read word and hardwired output
   // ------
   task automatic load_check(input logic [1:0] s);
      logic [31:0] r;
      logic        e;
      logic [11:0] a;
      logic [255:0] ek;
      for (int i = 0; i < 31; i++)
         img[i] = $random(seed);
      img[6][1:0] = s;
      for (int i = 0; i < 31; i++)
         i_fuse.mem[i] = img[i];
      // Masked case keeps the line low while the event is raised
      apb(1'b1, `OFS_EV_ENA, (s == 2'h2) ? 32'h0000_0000 : 32'h0000_0003, r, e);
      apb(1'b1, `OFS_CMD, `CMD_LOAD, r, e);
      apb(1'b0, `OFS_CMD, '0, r, e);
      chk("cmd_busy", r, `CMD_LOAD);
      wait_cmd();
      chk("irq_load", irq, s != 2'h2);
      apb(1'b0, `OFS_EV_RAW, '0, r, e);
      chk("ev_raw_load", r, 32'h0000_0001);
      apb(1'b1, `OFS_EV_CLR, 32'h0000_0001, r, e);
      apb(1'b0, `OFS_EV_RAW, '0, r, e);
      chk("ev_raw_clr", r, 32'h0000_0000);
      chk("irq_clr", irq, 1'b0);
      // Array contents change and a key write is tried: reads must not move
      for (int i = 0; i < 31; i++)
         i_fuse.mem[i] = ~img[i];
      apb(1'b1, `OFS_KEY_ONE, $random(seed), r, e);
      for (int i = 0; i < 7; i++)
      begin
         apb(1'b0, 12'(4*i), '0, r, e);
         chk("sys_word", r, img[i] & sys_mask[i]);
         chk("hw_sys", hw_sysparam[i], img[i] & sys_mask[i]);
      end
      for (int b = 0; b < 3; b++)
      begin
         ek = exp_key(b, s);
         for (int k = 0; k < 8; k++)
         begin
            a = `OFS_KEY_ONE + 12'(32*b + 4*k);
            apb(1'b0, a, '0, r, e);
            chk("key_word", r, ek[32*k +: 32]);
         end
      end
      chk("hw_key_one", hw_key_one, exp_key(0, s));
      chk("hw_key_two", hw_key_two, exp_key(1, s));
      chk("hw_key_three", hw_key_three, exp_key(2, s));
   endtask : load_check

   // ------
   // Main sequence
   // ------
   initial
   begin
      logic [31:0] r;
      logic        e;
      seed      = 32'h0ca1_48ba;
      failures  = 0;
      cmp_count = 0;
      presetn   = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = '0;
      pwdata    = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      chk("hw_sys_reset", hw_sysparam, '0);
      for (int s = 0; s < 4; s++)
         load_check(2'(s));
      // Burn of random length, 1 to 20 cycles, from the array side
      i_fuse.burn_wait = 1 + ($unsigned($random(seed)) % 20);
      apb(1'b1, `OFS_CMD, `CMD_BURN, r, e);
      wait_cmd();
      apb(1'b0, `OFS_EV_ST, '0, r, e);
      chk("ev_st_burn", r, 32'h0000_0002);
      chk("irq_burn", irq, 1'b1);
      apb(1'b1, `OFS_EV_CLR, 32'h0000_0002, r, e);
      apb(1'b0, `OFS_EV_RAW, '0, r, e);
      chk("ev_raw_burn_clr", r, 32'h0000_0000);
      // Unmapped and misaligned places are refused
      foreach (sys_mask[i])
         if (i < 2)
         begin
            apb(1'b0, (i == 0) ? 12'h200 : 12'h002, '0, r, e);
            chk("err_flag", e, 1'b1);
            chk("err_data", r, 32'h0000_0000);
         end
      complete_run();
   end

   // Watchdog: runs are under a thousand cycles, so this only cuts a hang
   initial
   begin
      #(40 * 20000);
      failures++;
      $display("Watchdog expired");
      complete_run();
   end
endmodule : fuse_parameter_readout_bench
`default_nettype wire
